// ---- pkg/half_bridge_spi_pkg.sv ----
/*
 * Constants and carrier types for the half-bridge serial control port.
 * Assumes a 40 MHz system clock; long filter counts are overridable at the top.
 */
package half_bridge_spi_pkg;

    // ------------------------------------------------------------------
    // frame and clock
    // ------------------------------------------------------------------
    localparam int unsigned FRAME_BITS       = 16;
    localparam int unsigned CLK_MHZ          = 40;

    // ------------------------------------------------------------------
    // command and status bit positions
    // ------------------------------------------------------------------
    localparam int unsigned BIT_OV_ENABLE    = 15;
    localparam int unsigned BIT_UL_ENABLE    = 14;
    localparam int unsigned BIT_OC_SELECT    = 13;
    localparam int unsigned BIT_SWITCH_LO    = 1;
    localparam int unsigned BIT_STATUS_RESET = 0;
    localparam int unsigned BIT_SUPPLY_FAULT = 15;
    localparam int unsigned BIT_UNDERLOAD    = 14;
    localparam int unsigned BIT_OVERCURRENT  = 13;
    localparam int unsigned BIT_SHOOT        = 12;
    localparam int unsigned BIT_THERMAL      = 0;

    // ------------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------------
    localparam logic [15:0] CONTROL_RESET    = 16'h0000;
    localparam logic [15:0] FAULT_RESET      = 16'h0000;

    // ------------------------------------------------------------------
    // fault filter times (us) and derived cycle counts
    // ------------------------------------------------------------------
    localparam int unsigned OC_LONG_US       = 200;
    localparam int unsigned OC_SHORT_US      = 25;
    localparam int unsigned UNDERLOAD_US     = 350;
    localparam int unsigned SUPPLY_FILTER_US = 10;
    localparam int unsigned THERMAL_FILTER_US = 10;
    localparam int unsigned OC_LONG_CYCLES   = OC_LONG_US * CLK_MHZ;
    localparam int unsigned OC_SHORT_CYCLES  = OC_SHORT_US * CLK_MHZ;
    localparam int unsigned UNDERLOAD_CYCLES = UNDERLOAD_US * CLK_MHZ;
    localparam int unsigned SUPPLY_CYCLES    = SUPPLY_FILTER_US * CLK_MHZ;
    localparam int unsigned THERMAL_CYCLES   = THERMAL_FILTER_US * CLK_MHZ;
    localparam int unsigned FILTER_WIDTH     = 16;

    // command word as shifted in, bit 15 first in this layout
    typedef struct packed {
        logic       overvoltage_shutdown_enable;
        logic       underload_shutdown_enable;
        logic       overcurrent_delay_select;
        logic [5:0] unused;
        logic [5:0] switch_enable;   // {h3,l3,h2,l2,h1,l1}
        logic       status_reset_request;
    } control_type;

    // fault and status word shifted out
    typedef struct packed {
        logic       supply_fault_flag;
        logic       underload_fault_flag;
        logic       overcurrent_fault_flag;
        logic       shoot_through_flag;
        logic [4:0] unused;
        logic [5:0] switch_state;
        logic       thermal_warning_flag;
    } status_type;

    // raw detector inputs from the analog side
    typedef struct packed {
        logic       supply_overvoltage;
        logic       supply_undervoltage;
        logic       underload;
        logic       thermal_warning;
        logic [5:0] overcurrent;     // one per switch, same order as enables
    } detect_type;

endpackage

// ---- src/half_bridge_spi_command_status.sv ----
/*
 * Serial command/status port and protection latching of a triple
 * half-bridge driver. Pins chip_select_n, sclk, si and the analog detector
 * levels arrive asynchronously and are synchronised to clk_sys; the serial
 * clock must stay well below clk_sys/4 (bench: 200 ns period vs 25 ns).
 */
//
// What this block does
// - sixteen bit words, least significant bit first
// - chip select rise moves word to control
// - serial output driven only while selected
// - latch only after at least sixteen clocks
// - counter armed by select fall, counts rises
// - valid frame clears underload and thermal flags
// - persisting faults re-latch after filter time
// - status shifts out while command shifts in
// - daisy chain passes input through, long frames
// - bit 15 enables overvoltage shutdown
// - bit 14 enables underload shutdown
// - bit 13 picks overcurrent filter time
// - bits 6..1 switch drivers, report state
// - bit 0 requests latched status reset
// - status bit 15 reports supply fault
// - status bits 14,13,12,0 report faults
// - supply flag cleared only by reset request
// - shoot-through driver stays off until cleared
`timescale 1ns/1ps

module half_bridge_spi_command_status #(
    parameter int unsigned OC_LONG_COUNT   = half_bridge_spi_pkg::OC_LONG_CYCLES,
    parameter int unsigned UNDERLOAD_COUNT = half_bridge_spi_pkg::UNDERLOAD_CYCLES
) (
    input  wire logic                            clk_sys,
    input  wire logic                            reset,
    input  wire logic                            chip_select_n,
    input  wire logic                            sclk,
    input  wire logic                            si,
    input  wire half_bridge_spi_pkg::detect_type detect,
    output logic                                 so_out,
    output logic                                 so_oe,
    output logic [5:0]                           switch_drive,
    output half_bridge_spi_pkg::control_type     control_command_word,
    output half_bridge_spi_pkg::status_type      fault_status_word
);

    // ------------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------------
    localparam int unsigned PIN_COUNT = 3 + $bits(half_bridge_spi_pkg::detect_type);

    logic [PIN_COUNT-1:0] pin_meta;
    logic [PIN_COUNT-1:0] pin_sync;
    logic                 cs_prev;
    logic                 sclk_prev;

    // two flops per pin; only the second stage is read by logic
    // reset to the pins' idle levels so no false edge or fault follows reset
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            pin_meta <= {1'b1, {(PIN_COUNT-1){1'b0}}};
            pin_sync <= {1'b1, {(PIN_COUNT-1){1'b0}}};
        end else begin
            pin_meta <= {chip_select_n, sclk, si, detect};
            pin_sync <= pin_meta;
        end
    end

    logic                            cs_n_s;
    logic                            sclk_s;
    logic                            si_s;
    half_bridge_spi_pkg::detect_type det_s;

    assign cs_n_s = pin_sync[PIN_COUNT-1];
    assign sclk_s = pin_sync[PIN_COUNT-2];
    assign si_s   = pin_sync[PIN_COUNT-3];
    assign det_s  = pin_sync[PIN_COUNT-4:0];

    // edge history on the synchronised levels
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            cs_prev   <= 1'b1;
            sclk_prev <= 1'b0;
        end else begin
            cs_prev   <= cs_n_s;
            sclk_prev <= sclk_s;
        end
    end

    logic cs_fall;
    logic cs_rise;
    logic sclk_rise;

    assign cs_fall   = cs_prev & ~cs_n_s;
    assign cs_rise   = ~cs_prev & cs_n_s;
    assign sclk_rise = ~cs_n_s & ~sclk_prev & sclk_s;

    // ------------------------------------------------------------------
    // shift register and frame length check
    // ------------------------------------------------------------------
    logic [15:0] shift_word;
    logic [4:0]  bit_count;
    logic        frame_valid;

    // one register serves both directions: status leaves at bit 0 while
    // input enters at bit 15, so after 16 clocks the input word sits
    // aligned and longer frames simply pass earlier bits downstream
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            shift_word <= half_bridge_spi_pkg::FAULT_RESET;
        end else if (cs_fall) begin
            shift_word <= fault_status_word;
        end else if (sclk_rise) begin
            shift_word <= {si_s, shift_word[15:1]};
        end
    end

    // saturating count of serial clock rises inside a frame
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            bit_count <= 5'h00;
        end else if (cs_fall) begin
            bit_count <= 5'h00;
        end else if (sclk_rise && bit_count < 5'(half_bridge_spi_pkg::FRAME_BITS)) begin
            bit_count <= bit_count + 5'h01;
        end
    end

    assign frame_valid = cs_rise && bit_count >= 5'(half_bridge_spi_pkg::FRAME_BITS);

    // serial output pins straight from flops
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            so_oe  <= 1'b0;
            so_out <= 1'b0;
        end else begin
            so_oe  <= ~cs_n_s;
            so_out <= cs_fall ? fault_status_word[0] : shift_word[0];
        end
    end

    // ------------------------------------------------------------------
    // control register
    // ------------------------------------------------------------------
    half_bridge_spi_pkg::control_type next_control;

    assign next_control = shift_word;

    // short frames fall through and leave the word untouched
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            control_command_word <= half_bridge_spi_pkg::CONTROL_RESET;
        end else if (frame_valid) begin
            control_command_word <= next_control;
        end
    end

    logic fault_clear;
    logic status_reset;

    assign fault_clear  = frame_valid;
    assign status_reset = frame_valid && next_control.status_reset_request;

    // ------------------------------------------------------------------
    // fault filters
    // ------------------------------------------------------------------
    localparam int unsigned FILTERS = 9;

    logic [FILTERS-1:0] condition;
    logic [FILTERS-1:0] filtered;

    assign condition = {det_s.supply_overvoltage | det_s.supply_undervoltage,
                        det_s.underload, det_s.thermal_warning, det_s.overcurrent};

    // limit per filter; overcurrent follows the delay select bit
    function automatic logic [15:0] filter_limit(input int unsigned idx, input logic short_sel);
        logic [15:0] lim;
        lim = 16'(half_bridge_spi_pkg::THERMAL_CYCLES);
        if (idx < 6) begin
            lim = short_sel ? 16'(half_bridge_spi_pkg::OC_SHORT_CYCLES)
                            : 16'(OC_LONG_COUNT);
        end else if (idx == 7) begin
            lim = 16'(UNDERLOAD_COUNT);
        end else if (idx == 8) begin
            lim = 16'(half_bridge_spi_pkg::SUPPLY_CYCLES);
        end
        return lim;
    endfunction

    // a clear restarts each timer so a lasting fault returns after the
    // full filter time rather than the instant it was cleared
    genvar gi;
    generate
        for (gi = 0; gi < FILTERS; gi++) begin : g_filter
            logic [15:0] filter_count;
            always_ff @(posedge clk_sys) begin
                if (reset) begin
                    filter_count <= 16'h0000;
                end else if (!condition[gi] || fault_clear) begin
                    filter_count <= 16'h0000;
                end else if (filter_count < filter_limit(gi,
                             control_command_word.overcurrent_delay_select)) begin
                    filter_count <= filter_count + 16'h0001;
                end
            end
            // masked in the clearing cycle, else the old count re-sets the flag at once
            assign filtered[gi] = condition[gi] && !fault_clear
                                && (filter_count >= filter_limit(gi,
                                    control_command_word.overcurrent_delay_select));
        end
    endgenerate

    // ------------------------------------------------------------------
    // latched fault flags; the clear wins over a filter set in the clearing cycle, a shoot-through set wins
    // ------------------------------------------------------------------
    logic       supply_flag;
    logic       underload_flag;
    logic       overcurrent_flag;
    logic       thermal_flag;
    logic       shoot_flag;
    logic [5:0] oc_latched;
    logic [2:0] shoot_channel;
    logic [2:0] shoot_attempt;

    // both switches of one channel commanded on at once
    always_comb begin
        for (int c = 0; c < 3; c++) begin
            shoot_attempt[c] = control_command_word.switch_enable[2*c]
                             & control_command_word.switch_enable[2*c+1];
        end
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            supply_flag <= 1'b0;
        end else begin
            supply_flag <= (supply_flag & ~status_reset) | filtered[8];
        end
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            underload_flag <= 1'b0;
            thermal_flag   <= 1'b0;
        end else begin
            underload_flag <= (underload_flag & ~fault_clear) | filtered[7];
            thermal_flag   <= (thermal_flag & ~fault_clear) | filtered[6];
        end
    end

    // overcurrent switches latch off and only a reset request frees them
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            oc_latched       <= 6'h00;
            overcurrent_flag <= 1'b0;
        end else begin
            oc_latched       <= (oc_latched & ~{6{status_reset}}) | filtered[5:0];
            overcurrent_flag <= (overcurrent_flag & ~status_reset) | (|filtered[5:0]);
        end
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            shoot_flag    <= 1'b0;
            shoot_channel <= 3'h0;
        end else begin
            shoot_flag    <= (shoot_flag & ~status_reset) | (|shoot_attempt);
            shoot_channel <= (shoot_channel & ~{3{status_reset}}) | shoot_attempt;
        end
    end

    // ------------------------------------------------------------------
    // driver gating
    // ------------------------------------------------------------------
    logic [5:0] next_drive;
    logic       global_off;

    assign global_off = (control_command_word.overvoltage_shutdown_enable
                         & det_s.supply_overvoltage)
                      | det_s.supply_undervoltage
                      | (control_command_word.underload_shutdown_enable
                         & underload_flag);

    // command bits kept, so outputs return once an overvoltage passes
    always_comb begin
        next_drive = control_command_word.switch_enable & ~oc_latched;
        for (int c = 0; c < 3; c++) begin
            if (shoot_channel[c] || shoot_attempt[c]) begin
                next_drive[2*c]   = 1'b0;
                next_drive[2*c+1] = 1'b0;
            end
        end
        if (global_off) begin
            next_drive = 6'h00;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            switch_drive <= 6'h00;
        end else begin
            switch_drive <= next_drive;
        end
    end

    // ------------------------------------------------------------------
    // status word, registered from the flags on every clock
    // ------------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            fault_status_word <= half_bridge_spi_pkg::FAULT_RESET;
        end else begin
            fault_status_word.supply_fault_flag      <= supply_flag;
            fault_status_word.underload_fault_flag   <= underload_flag;
            fault_status_word.overcurrent_fault_flag <= overcurrent_flag;
            fault_status_word.shoot_through_flag     <= shoot_flag;
            fault_status_word.unused                 <= 5'h00;
            fault_status_word.switch_state           <= switch_drive;
            fault_status_word.thermal_warning_flag   <= thermal_flag;
        end
    end

endmodule

// ---- tb/half_bridge_spi_command_status_asserts.sv ----
/*
 * Checker for the half-bridge serial port: so enable, so timing, control
 * update and sticky flags.
 * Assumes the pins are driven off the clk_sys falling edge.
 */
`timescale 1ns/1ps
module half_bridge_spi_command_status_asserts #(
    parameter int unsigned OC_LONG_COUNT   = 40,
    parameter int unsigned UNDERLOAD_COUNT = 60
) (
    input wire logic                            clk_sys,
    input wire logic                            reset,
    input wire logic                            chip_select_n,
    input wire logic                            sclk,
    input wire logic                            si,
    input wire half_bridge_spi_pkg::detect_type  detect,
    input wire logic                            so_out,
    input wire logic                            so_oe,
    input wire logic [5:0]                      switch_drive,
    input wire half_bridge_spi_pkg::control_type control_command_word,
    input wire half_bridge_spi_pkg::status_type  fault_status_word
);
    // --------------------------------------------------------------
    // frame monitor
    // --------------------------------------------------------------
    logic [5:0]  bit_cnt;
    logic [15:0] bits_in;
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (reset);

    // saturating count and last sixteen bits, seen on the raw pins
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            bit_cnt <= 6'h00;
            bits_in <= 16'h0000;
        end else if ($fell(chip_select_n)) begin
            bit_cnt <= 6'h00;
        end else if (!chip_select_n && $rose(sclk)) begin
            bits_in <= {si, bits_in[15:1]};
            if (bit_cnt != 6'h3F) begin
                bit_cnt <= bit_cnt + 6'h01;
            end
        end
    end

    // --------------------------------------------------------------
    // assertions
    // --------------------------------------------------------------
    a_oe_idle: assert property (chip_select_n [*4] |-> !so_oe)
        else $error("so_oe high while deselected");
    a_oe_rise: assert property ($fell(chip_select_n) |-> ##[2:5] so_oe)
        else $error("so_oe late after select");
    a_ctl_when: assert property (
        !$stable(control_command_word) |-> chip_select_n && $past(chip_select_n, 2))
        else $error("control moved inside a frame");
    a_ctl_len: assert property (
        !$stable(control_command_word) |-> bit_cnt >= 6'h10)
        else $error("control moved after a short frame");
    a_ctl_bits: assert property (
        !$stable(control_command_word) |-> control_command_word == bits_in)
        else $error("control differs from last sixteen bits");
    a_so_hold: assert property (!chip_select_n && $fell(sclk) |=> $stable(so_out) [*2])
        else $error("so changed in clock low half");
    a_no_shoot: assert property (
        switch_drive[1:0] != 2'b11 && switch_drive[3:2] != 2'b11
        && switch_drive[5:4] != 2'b11)
        else $error("both switches of a channel on");
    a_drive_cmd: assert property (
        |(switch_drive & ~control_command_word.switch_enable)
        |=> !(|(switch_drive & ~control_command_word.switch_enable)))
        else $error("switch on without command");
    a_supply_keep: assert property (
        $fell(fault_status_word.supply_fault_flag)
        |-> ##[0:2] control_command_word.status_reset_request)
        else $error("supply flag cleared without reset request");
    a_shoot_keep: assert property (
        $fell(fault_status_word.shoot_through_flag)
        |-> ##[0:2] control_command_word.status_reset_request)
        else $error("shoot flag cleared without reset request");
    a_warn_frame: assert property (
        $fell(fault_status_word.thermal_warning_flag) |-> chip_select_n && bit_cnt >= 6'h10)
        else $error("thermal flag cleared outside valid frame");
endmodule

bind half_bridge_spi_command_status half_bridge_spi_command_status_asserts #(
    .OC_LONG_COUNT(OC_LONG_COUNT), .UNDERLOAD_COUNT(UNDERLOAD_COUNT)
) chk_u (.clk_sys, .reset, .chip_select_n, .sclk, .si, .detect, .so_out, .so_oe,
    .switch_drive, .control_command_word, .fault_status_word);

// ---- tb/spi_host_model.sv ----
/*
 * Host controller model driving the serial port pins.
 * Assumes clk_sys at 25 ns; one serial clock is eight clk_sys periods.
 */
`timescale 1ns/1ps
module spi_host_model (
    input  wire logic clk_sys,
    input  wire logic so_out,
    input  wire logic so_oe,
    output logic      chip_select_n,
    output logic      sclk,
    output logic      si
);
    logic so_last;
    logic so_line;

    // a released so line shows the inverse of its last bit, never a stale match
    always @(posedge clk_sys) begin
        if (so_oe) begin
            so_last <= so_out;
        end
    end
    assign so_line = so_oe ? so_out : ~so_last;

    // pull-up on select, pull-downs on clock and data
    initial begin
        chip_select_n = 1'b1;
        sclk = 1'b0;
        si = 1'b0;
    end

    // one frame of n bits, least significant first; clock stands still outside
    task automatic xfer(input int n, input logic [31:0] din, output logic [31:0] dout);
        dout = 32'h00000000;
        @(negedge clk_sys);
        chip_select_n = 1'b0;
        repeat (8) @(negedge clk_sys);
        for (int i = 0; i < n; i++) begin
            si = din[i];
            repeat (4) @(negedge clk_sys);
            dout[i] = so_line;
            sclk = 1'b1;
            repeat (4) @(negedge clk_sys);
            sclk = 1'b0;
        end
        repeat (4) @(negedge clk_sys);
        chip_select_n = 1'b1;
        si = 1'b0;
        repeat (200) @(negedge clk_sys);
    endtask
endmodule

// ---- tb/test_half_bridge_spi_command_status.sv ----
/*
 * Self-checking bench for the half-bridge serial port.
 * Assumes the host model and checker files are compiled before it.
 */
`timescale 1ns/1ps
module test_half_bridge_spi_command_status;
    logic                            clk_sys;
    logic                            reset;
    logic                            chip_select_n;
    logic                            sclk;
    logic                            si;
    logic                            so_out;
    logic                            so_oe;
    logic [5:0]                      switch_drive;
    logic [31:0]                     rx;
    half_bridge_spi_pkg::detect_type  detect;
    half_bridge_spi_pkg::control_type control_command_word;
    half_bridge_spi_pkg::status_type  fault_status_word;
    int                              miscompares = 0;
    int                              tests_run = 0;

    initial begin
        clk_sys = 1'b0;
        forever #12.5 clk_sys = ~clk_sys;
    end

    // short filter counts keep the run brief
    half_bridge_spi_command_status #(.OC_LONG_COUNT(40), .UNDERLOAD_COUNT(60)) dut_u (
        .clk_sys(clk_sys), .reset(reset), .chip_select_n(chip_select_n), .sclk(sclk),
        .si(si), .detect(detect), .so_out(so_out), .so_oe(so_oe),
        .switch_drive(switch_drive), .control_command_word(control_command_word),
        .fault_status_word(fault_status_word));
    spi_host_model host_u (.clk_sys(clk_sys), .so_out(so_out), .so_oe(so_oe),
        .chip_select_n(chip_select_n), .sclk(sclk), .si(si));

    task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
        tests_run++;
        if (got !== exp) begin
            miscompares++;
            $display("[FAIL] %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic xf(input int n, input logic [31:0] d);
        host_u.xfer(n, d, rx);
    endtask
    task automatic w(input int n);
        repeat (n) @(negedge clk_sys);
    endtask
    task automatic wrap_up;
        $display("comparisons %0d mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // watchdog: the sequence needs about 8800 cycles
    initial begin
        w(60000);
        miscompares++;
        wrap_up();
    end

    // ----------------------------------------------------------------
    // main sequence: all inputs change at the falling edge
    // ----------------------------------------------------------------
    initial begin
        reset = 1'b1;
        detect = '0;
        w(12);
        reset = 1'b0;
        w(6);
        chk("control", 16'h0000, control_command_word);
        chk("so_oe", 16'h0000, {15'h0000, so_oe});
        xf(16, 32'hA04C);
        chk("control", 16'hA04C, control_command_word);
        chk("drive", 16'h0026, {10'h000, switch_drive});
        xf(16, 32'hA04C);
        chk("so word", 16'h004C, rx[15:0]);
        xf(8, 32'h00FF);
        chk("control", 16'hA04C, control_command_word);
        xf(24, 32'h2008A5);
        chk("control", 16'h2008, control_command_word);
        chk("so tail", 16'h00A5, {8'h00, rx[23:16]});
        detect.thermal_warning = 1'b1;
        w(450);
        chk("status", 16'h0009, fault_status_word);
        xf(16, 32'h2008);
        chk("status", 16'h0008, fault_status_word);
        w(300);
        chk("status", 16'h0009, fault_status_word);
        detect.thermal_warning = 1'b0;
        detect.overcurrent[2] = 1'b1;
        w(100);
        chk("status", 16'h0009, fault_status_word);
        w(1000);
        chk("status", 16'h2001, fault_status_word);
        detect.overcurrent[2] = 1'b0;
        xf(16, 32'h0008);
        chk("status", 16'h2000, fault_status_word);
        xf(16, 32'h0009);
        chk("status", 16'h0008, fault_status_word);
        detect.overcurrent[2] = 1'b1;
        w(80);
        chk("status", 16'h2000, fault_status_word);
        detect.overcurrent[2] = 1'b0;
        xf(16, 32'h8009);
        detect.supply_overvoltage = 1'b1;
        w(500);
        chk("status", 16'h8000, fault_status_word);
        detect.supply_overvoltage = 1'b0;
        w(20);
        chk("status", 16'h8008, fault_status_word);
        xf(16, 32'h0008);
        chk("status", 16'h8008, fault_status_word);
        detect.supply_overvoltage = 1'b1;
        w(500);
        chk("drive", 16'h0004, {10'h000, switch_drive});
        detect.supply_overvoltage = 1'b0;
        xf(16, 32'h0009);
        chk("status", 16'h0008, fault_status_word);
        xf(16, 32'h4008);
        detect.underload = 1'b1;
        w(150);
        chk("status", 16'h4000, fault_status_word);
        detect.underload = 1'b0;
        xf(16, 32'h0008);
        chk("status", 16'h0008, fault_status_word);
        xf(16, 32'h0006);
        chk("status", 16'h1000, fault_status_word);
        xf(16, 32'h0004);
        chk("drive", 16'h0000, {10'h000, switch_drive});
        chk("so word", 16'h1000, rx[15:0]);
        xf(16, 32'h0005);
        chk("status", 16'h0004, fault_status_word);
        // undervoltage switches all off whatever the enable bit says
        detect.supply_undervoltage = 1'b1;
        w(500);
        chk("drive", 16'h0000, {10'h000, switch_drive});
        chk("status", 16'h8000, fault_status_word);
        detect.supply_undervoltage = 1'b0;
        w(20);
        chk("status", 16'h8004, fault_status_word);
        wrap_up();
    end
endmodule
